// *** sdpf_core.v ***
/*
  Serial data path and format selection of one serial channel:
  receive shifter into a read-only receive buffer, transmit buffer
  into a transmit shifter, format register, prescaler and bit-rate
  counter. Assumes a single 20 MHz clock, a synchronous active-high
  reset, a standby level from same-clock logic and an external rxd pin.
*/
//Behaviour
//- Receiver shifts rxd bits into its shifter in arrival order, LSB first.
//- Neither shifter is reachable by any CPU read or write.
//- A full character without framing or parity error moves to the receive buffer if RDRF is clear and MP wait keeps it; shifter is free at once.
//- Receive buffer is read-only; reset and standby zero it.
//- Transmitter sends its shifter on txd, LSB first.
//- Empty transmit shifter takes the buffer and starts sending.
//- No load into the transmit shifter while the buffer-empty flag is set.
//- Transmit buffer read/write always; reset and standby set it to ones.
//- Format register read/write always; reset and standby clear it.
//- Format bit 7 selects asynchronous (0) or synchronous (1) operation.
//- Bit 6 picks 8 or 7 data bits in async; sync always 8.
//- With 7-bit characters the buffer MSB is not sent.
//- Bit 5 adds and checks parity in async only.
//- Bit 4 picks even (0) or odd (1) parity over data plus parity.
//- Bit 3 picks one or two stop bits in async; stop bits are one.
//- Receiver checks only the first stop bit.
//- A zero in the second stop slot starts the next character.
//- Synchronous mode sends no stop bits; stop field ignored.
//- Bit 2 selects multiprocessor format in async, overriding parity.
//- Bits 1:0 tap the clock undivided, divided by 4, 16 or 64.
//- With transmit on, sending starts after buffer write and flag clear.
//- With transmit disabled, the buffer-empty flag is held at one.
`include "sdpf_map.vh"

module sdpf_core (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  input wire standby_in,
  // Register port
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // Serial line
  input wire rxd_in,
  output reg txd_out
);

  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_STOP2 = 3'h5;

  wire clr = rst_in | standby_in;

  reg [7:0] serial_format_control;
  reg [7:0] rate_div;
  reg [7:0] ctrl;
  reg [7:0] transmit_data_buffer;
  reg [7:0] receive_data_buffer;
  reg [7:0] serial_flag_register;
  reg [7:0] transmit_shifter;
  reg [7:0] receive_shifter;

  // Decoded format
  wire is_sync = serial_format_control[`SDPF_FMT_SYNC];
  wire chr7 = ~is_sync & serial_format_control[`SDPF_FMT_CHR7];
  wire mp_fmt = ~is_sync & serial_format_control[`SDPF_FMT_MP];
  wire par_on = ~is_sync & ~mp_fmt
    & serial_format_control[`SDPF_FMT_PAR_EN];
  wire odd_par = serial_format_control[`SDPF_FMT_ODD];
  wire two_stop = serial_format_control[`SDPF_FMT_STOP2];
  wire [1:0] pre_sel = serial_format_control[`SDPF_FMT_PRE_HI:
    `SDPF_FMT_PRE_LO];
  wire [2:0] last_bit = chr7 ? `SDPF_LAST7 : `SDPF_LAST8;
  wire [3:0] bit_last = is_sync ? `SDPF_SYNC_LAST : `SDPF_ASYNC_LAST;
  wire tx_en = ctrl[`SDPF_CTL_TX_EN];
  wire rx_en = ctrl[`SDPF_CTL_RX_EN];
  wire transmit_buffer_empty_flag = serial_flag_register[`SDPF_FLG_TRANSMIT_BUFFER_EMPTY_FLAG];
  wire rdrf = serial_flag_register[`SDPF_FLG_RDRF];

  // Prescaler and bit-rate counter
  reg [5:0] pre_cnt;
  reg [7:0] rate_cnt;
  reg sub_tick;
  reg pre_tick;

  always @* begin
    case (pre_sel)
      `SDPF_PRE_DIV1: pre_tick = 1'b1;
      `SDPF_PRE_DIV4: pre_tick = (pre_cnt[1:0] == `SDPF_TAP4);
      `SDPF_PRE_DIV16: pre_tick = (pre_cnt[3:0] == `SDPF_TAP16);
      default: pre_tick = (pre_cnt == `SDPF_TAP64);
    endcase
  end

  always @(posedge clk_in) begin
    if (clr) begin
      pre_cnt <= 6'h00;
      rate_cnt <= 8'h00;
      sub_tick <= 1'b0;
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
      sub_tick <= 1'b0;
      if (pre_tick) begin
        if (rate_cnt == rate_div) begin
          rate_cnt <= 8'h00;
          sub_tick <= 1'b1;
        end else begin
          rate_cnt <= rate_cnt + 8'h01;
        end
      end
    end
  end

  // Pin synchroniser: level changes once stages two and three agree
  reg rx_s1;
  reg rx_s2;
  reg rx_s3;
  reg rx_lvl;
  always @(posedge clk_in) begin
    if (clr) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_lvl <= 1'b1;
    end else begin
      rx_s1 <= rxd_in;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3)
        rx_lvl <= rx_s3;
    end
  end

  // Receiver
  reg [2:0] rx_state;
  reg [3:0] rx_sub;
  reg [2:0] rx_bit;
  reg rx_par;
  reg rx_mpb;
  reg rx_done;
  reg rx_fer;
  reg rx_per;
  reg [7:0] rx_word;
  wire rx_at = sub_tick & (rx_sub == bit_last);
  wire rx_ones = ^rx_word;

  always @(posedge clk_in) begin
    if (clr) begin
      rx_state <= ST_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_par <= 1'b0;
      rx_mpb <= 1'b0;
      rx_done <= 1'b0;
      rx_fer <= 1'b0;
      rx_per <= 1'b0;
      receive_shifter <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      if (sub_tick)
        rx_sub <= (rx_sub == bit_last) ? 4'h0 : rx_sub + 4'h1;
      case (rx_state)
        ST_IDLE: begin
          rx_sub <= 4'h0;
          rx_bit <= 3'h0;
          receive_shifter <= 8'h00;
          if (rx_en & is_sync)
            rx_state <= ST_DATA;
          else if (rx_en & ~rx_lvl)
            rx_state <= ST_START;
        end
        ST_START: begin
          if (sub_tick & (rx_sub == `SDPF_ASYNC_MID)) begin
            rx_sub <= 4'h0;
            rx_state <= rx_lvl ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_at) begin
            receive_shifter[rx_bit] <= rx_lvl;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == last_bit) begin
              if (is_sync) begin
                rx_fer <= 1'b0;
                rx_per <= 1'b0;
                rx_mpb <= 1'b0;
                rx_done <= 1'b1;
                rx_state <= rx_en ? ST_DATA : ST_IDLE;
              end else if (par_on | mp_fmt) begin
                rx_state <= ST_PAR;
              end else begin
                rx_state <= ST_STOP;
              end
            end
          end
        end
        ST_PAR: begin
          if (rx_at) begin
            rx_par <= rx_lvl;
            rx_state <= ST_STOP;
          end
        end
        ST_STOP: begin
          // Only the first stop slot is sampled; idle catches a new start
          if (rx_at) begin
            rx_fer <= ~rx_lvl;
            rx_per <= par_on & ((rx_ones ^ rx_par) != odd_par);
            rx_mpb <= mp_fmt & rx_par;
            rx_done <= 1'b1;
            rx_state <= ST_IDLE;
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  always @* begin
    rx_word = receive_shifter;
    if (chr7)
      rx_word[7] = 1'b0;
  end

  // Multiprocessor wait: drop characters until one carries the flag bit
  wire mp_wait = mp_fmt & ctrl[`SDPF_CTL_MP_WAIT];
  wire rx_keep = rx_done & ~(mp_wait & ~rx_mpb);
  wire rx_take = rx_keep & ~rdrf & ~rx_fer & ~rx_per;

  // Transmitter
  reg [2:0] tx_state;
  reg [3:0] tx_sub;
  reg [2:0] tx_bit;
  reg tx_load;
  wire tx_at = sub_tick & (tx_sub == bit_last);
  wire tx_ready = tx_en & ~transmit_buffer_empty_flag;
  wire tx_ones = chr7 ? ^transmit_shifter[6:0] : ^transmit_shifter;

  always @(posedge clk_in) begin
    if (clr) begin
      tx_state <= ST_IDLE;
      tx_sub <= 4'h0;
      tx_bit <= 3'h0;
      tx_load <= 1'b0;
      txd_out <= 1'b1;
      transmit_shifter <= 8'hFF;
    end else begin
      tx_load <= 1'b0;
      if (sub_tick)
        tx_sub <= (tx_sub == bit_last) ? 4'h0 : tx_sub + 4'h1;
      case (tx_state)
        ST_IDLE: begin
          txd_out <= 1'b1;
          tx_sub <= 4'h0;
          if (tx_ready) begin
            transmit_shifter <= transmit_data_buffer;
            tx_load <= 1'b1;
            tx_bit <= 3'h0;
            tx_state <= is_sync ? ST_DATA : ST_START;
          end
        end
        ST_START: begin
          txd_out <= 1'b0;
          if (tx_at)
            tx_state <= ST_DATA;
        end
        ST_DATA: begin
          txd_out <= transmit_shifter[tx_bit];
          if (tx_at) begin
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit != last_bit)
              tx_state <= ST_DATA;
            else if (is_sync)
              tx_state <= ST_STOP2;
            else if (par_on | mp_fmt)
              tx_state <= ST_PAR;
            else
              tx_state <= ST_STOP;
          end
        end
        ST_PAR: begin
          if (mp_fmt)
            txd_out <= serial_flag_register[`SDPF_FLG_MPBT];
          else
            txd_out <= tx_ones ^ odd_par;
          if (tx_at)
            tx_state <= ST_STOP;
        end
        ST_STOP: begin
          txd_out <= 1'b1;
          if (tx_at)
            tx_state <= two_stop ? ST_STOP2 : ST_IDLE;
          if (tx_at & ~two_stop & tx_ready) begin
            transmit_shifter <= transmit_data_buffer;
            tx_load <= 1'b1;
            tx_bit <= 3'h0;
            tx_state <= ST_START;
          end
        end
        ST_STOP2: begin
          // Async second stop; in sync mode a pass-through to idle, or straight to data when the buffer is ready
          txd_out <= is_sync ? txd_out : 1'b1;
          if (is_sync | tx_at)
            tx_state <= ST_IDLE;
          if ((is_sync | tx_at) & tx_ready) begin
            transmit_shifter <= transmit_data_buffer;
            tx_load <= 1'b1;
            tx_bit <= 3'h0;
            tx_state <= is_sync ? ST_DATA : ST_START;
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // Register writes
  wire wr_fmt = wr_in & (addr_in == `SDPF_OFS_FORMAT);
  wire wr_flg = wr_in & (addr_in == `SDPF_OFS_FLAGS);
  wire tx_idle = (tx_state == ST_IDLE) & ~tx_load;

  always @(posedge clk_in) begin
    if (clr) begin
      serial_format_control <= `SDPF_RST_FORMAT;
      rate_div <= `SDPF_RST_RATE;
      ctrl <= `SDPF_RST_CTRL;
      transmit_data_buffer <= `SDPF_RST_TXBUF;
      receive_data_buffer <= `SDPF_RST_RXBUF;
    end else begin
      if (wr_fmt)
        serial_format_control <= wdata_in;
      if (wr_in & (addr_in == `SDPF_OFS_RATE))
        rate_div <= wdata_in;
      if (wr_in & (addr_in == `SDPF_OFS_CTRL))
        ctrl <= wdata_in;
      if (rx_keep & rx_mpb)
        ctrl[`SDPF_CTL_MP_WAIT] <= 1'b0;
      if (wr_in & (addr_in == `SDPF_OFS_TXBUF))
        transmit_data_buffer <= wdata_in;
      if (rx_take)
        receive_data_buffer <= rx_word;
    end
  end

  // Flags: a hardware set wins over a software clear in the same cycle
  always @(posedge clk_in) begin
    if (clr) begin
      serial_flag_register <= `SDPF_RST_FLAGS;
    end else begin
      if (wr_flg) begin
        serial_flag_register[`SDPF_FLG_TRANSMIT_BUFFER_EMPTY_FLAG:`SDPF_FLG_PER] <=
          serial_flag_register[`SDPF_FLG_TRANSMIT_BUFFER_EMPTY_FLAG:`SDPF_FLG_PER]
          & wdata_in[`SDPF_FLG_TRANSMIT_BUFFER_EMPTY_FLAG:`SDPF_FLG_PER];
        serial_flag_register[`SDPF_FLG_MPBT] <= wdata_in[`SDPF_FLG_MPBT];
        if (~wdata_in[`SDPF_FLG_TRANSMIT_BUFFER_EMPTY_FLAG])
          serial_flag_register[`SDPF_FLG_TEND] <= 1'b0;
      end
      if (tx_load | ~tx_en)
        serial_flag_register[`SDPF_FLG_TRANSMIT_BUFFER_EMPTY_FLAG] <= 1'b1;
      if (tx_idle & transmit_buffer_empty_flag)
        serial_flag_register[`SDPF_FLG_TEND] <= 1'b1;
      if (rx_take)
        serial_flag_register[`SDPF_FLG_RDRF] <= 1'b1;
      if (rx_keep & rdrf)
        serial_flag_register[`SDPF_FLG_ORER] <= 1'b1;
      if (rx_keep & rx_fer)
        serial_flag_register[`SDPF_FLG_FER] <= 1'b1;
      if (rx_keep & rx_per)
        serial_flag_register[`SDPF_FLG_PER] <= 1'b1;
      if (rx_keep & mp_fmt)
        serial_flag_register[`SDPF_FLG_MPB] <= rx_mpb;
    end
  end

  // Read port: shifters and unused offsets read as zero
  always @(posedge clk_in) begin
    if (clr) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `SDPF_OFS_FORMAT: rdata_out <= serial_format_control;
        `SDPF_OFS_RATE: rdata_out <= rate_div;
        `SDPF_OFS_CTRL: rdata_out <= ctrl;
        `SDPF_OFS_TXBUF: rdata_out <= transmit_data_buffer;
        `SDPF_OFS_FLAGS: rdata_out <= serial_flag_register;
        `SDPF_OFS_RXBUF: rdata_out <= receive_data_buffer;
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule

// *** sdpf_map.vh ***
/*
  Register offsets, field positions, reset values and timing counts
  for the serial data path. Assumes plain inclusion by the core file.
*/
`ifndef SDPF_MAP_VH
`define SDPF_MAP_VH

// Register offsets on the 3-bit address port
`define SDPF_OFS_FORMAT 3'h0
`define SDPF_OFS_RATE 3'h1
`define SDPF_OFS_CTRL 3'h2
`define SDPF_OFS_TXBUF 3'h3
`define SDPF_OFS_FLAGS 3'h4
`define SDPF_OFS_RXBUF 3'h5

// Reset values
`define SDPF_RST_FORMAT 8'h00
`define SDPF_RST_RATE 8'hFF
`define SDPF_RST_CTRL 8'h00
`define SDPF_RST_TXBUF 8'hFF
`define SDPF_RST_RXBUF 8'h00
`define SDPF_RST_FLAGS 8'h84

// Format register fields
`define SDPF_FMT_SYNC 7
`define SDPF_FMT_CHR7 6
`define SDPF_FMT_PAR_EN 5
`define SDPF_FMT_ODD 4
`define SDPF_FMT_STOP2 3
`define SDPF_FMT_MP 2
`define SDPF_FMT_PRE_HI 1
`define SDPF_FMT_PRE_LO 0

// Control register fields
`define SDPF_CTL_TX_EN 5
`define SDPF_CTL_RX_EN 4
`define SDPF_CTL_MP_WAIT 3

// Flag register fields
`define SDPF_FLG_TRANSMIT_BUFFER_EMPTY_FLAG 7
`define SDPF_FLG_RDRF 6
`define SDPF_FLG_ORER 5
`define SDPF_FLG_FER 4
`define SDPF_FLG_PER 3
`define SDPF_FLG_TEND 2
`define SDPF_FLG_MPB 1
`define SDPF_FLG_MPBT 0

// Prescaler taps
`define SDPF_PRE_DIV1 2'h0
`define SDPF_PRE_DIV4 2'h1
`define SDPF_PRE_DIV16 2'h2
`define SDPF_PRE_DIV64 2'h3
`define SDPF_TAP4 2'h3
`define SDPF_TAP16 4'hF
`define SDPF_TAP64 6'h3F

// Sub-ticks per bit minus one and mid-bit point
`define SDPF_ASYNC_LAST 4'hF
`define SDPF_SYNC_LAST 4'h3
`define SDPF_ASYNC_MID 4'h7

// Data bit counts minus one
`define SDPF_LAST8 3'h7
`define SDPF_LAST7 3'h6

`endif

// *** sdpf_core_checker.sv ***
/*
  Port checker for sdpf_core, bound to every instance.
  Assumes the register map header and a single clock domain.
*/
`include "sdpf_map.vh"
module sdpf_chk (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  input wire standby_in,
  // Register port
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  // Serial line
  input wire rxd_in,
  input wire txd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tx_en;
  logic sync_md;
  wire any_rst = rst_in | standby_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (any_rst);
  // Shadows of the mode bits that the line checks depend on
  always_ff @(posedge clk_in) begin
    if (any_rst) tx_en <= 1'b0;
    else if (wr_in && addr_in == `SDPF_OFS_CTRL)
      tx_en <= wdata_in[`SDPF_CTL_TX_EN];
  end
  always_ff @(posedge clk_in) begin
    if (any_rst) sync_md <= 1'b0;
    else if (wr_in && addr_in == `SDPF_OFS_FORMAT)
      sync_md <= wdata_in[`SDPF_FMT_SYNC];
  end
  property p_rst_txd;
    disable iff (1'b0) any_rst |=> txd_out;
  endproperty
  a_rst_txd: assert property (p_rst_txd) else $error("line not idle");
  property p_rst_fmt;
    disable iff (1'b0) any_rst ##1 (!any_rst && rd_in &&
      addr_in == `SDPF_OFS_FORMAT) |=> rdata_out == 8'h00;
  endproperty
  a_rst_fmt: assert property (p_rst_fmt) else $error("format init");
  property p_rst_tx;
    disable iff (1'b0) any_rst ##1 (!any_rst && rd_in &&
      addr_in == `SDPF_OFS_TXBUF) |=> rdata_out == 8'hFF;
  endproperty
  a_rst_tx: assert property (p_rst_tx) else $error("txbuf init");
  property p_unmap;
    rd_in && addr_in[2:1] == 2'h3 |=> rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_tx_rw;
    wr_in && addr_in == `SDPF_OFS_TXBUF ##1 !wr_in ##1 rd_in &&
      addr_in == `SDPF_OFS_TXBUF |=> rdata_out == $past(wdata_in, 3);
  endproperty
  a_tx_rw: assert property (p_tx_rw) else $error("txbuf readback");
  property p_fmt_rw;
    wr_in && addr_in == `SDPF_OFS_FORMAT ##1 !wr_in ##1 rd_in &&
      addr_in == `SDPF_OFS_FORMAT |=> rdata_out == $past(wdata_in, 3);
  endproperty
  a_fmt_rw: assert property (p_fmt_rw) else $error("format readback");
  property p_rx_ro;
    rd_in && addr_in == `SDPF_OFS_RXBUF ##2 wr_in &&
      addr_in == `SDPF_OFS_RXBUF ##2 rd_in && addr_in == `SDPF_OFS_RXBUF
      |=> rdata_out == $past(rdata_out, 4);
  endproperty
  a_rx_ro: assert property (p_rx_ro) else $error("rxbuf written");
  property p_tx_gate;
    $fell(txd_out) |-> tx_en;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("sent while off");
  // Any async low bit that follows a fall keeps the line low for at least 8 clocks
  property p_start;
    $fell(txd_out) && !sync_md |-> (!txd_out) [*8];
  endproperty
  a_start: assert property (p_start) else $error("short low bit");
  c_tx: cover property ($fell(txd_out));
  c_rx_rd: cover property (rd_in && addr_in == `SDPF_OFS_RXBUF);
  c_fmt_wr: cover property (wr_in && addr_in == `SDPF_OFS_FORMAT);
endmodule

bind sdpf_core sdpf_chk u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .standby_in(standby_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .rxd_in(rxd_in), .txd_out(txd_out));

// *** sdpf_remote.sv ***
/*
  Remote serial transceiver: sends frames on the receive line and
  captures frames from the transmit line. Assumes the bench clock.
*/
module sdpf_remote (
  // Clock
  input wire logic clk_in,
  // Line
  input wire logic txd_in,
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled-up line: idle and released level is one
  initial rxd_out = 1'b1;
  task automatic send(input logic [23:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      rxd_out <= f[i];
      repeat (bt) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
  endtask
  // Sampled on the falling edge to stay clear of the launch edge
  task automatic grab(input int n, input int bt, output logic [11:0] f);
    int w;
    f = 12'hFFF;
    w = 0;
    while (txd_in !== 1'b0 && w < 4000) begin
      @(negedge clk_in);
      w++;
    end
    repeat (bt / 2) @(negedge clk_in);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (bt) @(negedge clk_in);
      f[i] = txd_in;
    end
  endtask
endmodule

// *** sdpf_core_tb.sv ***
/*
  Self-checking bench for sdpf_core with a remote line partner.
  Assumes the register map header and the bound checker.
*/
`include "sdpf_map.vh"
module sdpf_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] o_fmt = `SDPF_OFS_FORMAT;
  localparam logic [2:0] o_ctl = `SDPF_OFS_CTRL;
  localparam logic [2:0] o_tx = `SDPF_OFS_TXBUF;
  localparam logic [2:0] o_flg = `SDPF_OFS_FLAGS;
  localparam logic [2:0] o_rx = `SDPF_OFS_RXBUF;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic standby_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  wire [7:0] rdata_out;
  wire rxd;
  wire txd_out;
  int bad_count = 0;
  int checks = 0;
  logic [7:0] fm [7] = '{8'h00, 8'h68, 8'h30, 8'h34, 8'h01, 8'h02, 8'h03};
  logic [7:0] dt [7] = '{8'hA5, 8'hD3, 8'h4E, 8'h96, 8'h5A, 8'hC1, 8'h3F};

  sdpf_core uut (.clk_in(clk_in), .rst_in(rst_in), .standby_in(standby_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .rxd_in(rxd), .txd_out(txd_out));
  sdpf_remote far (.clk_in(clk_in), .txd_in(txd_out), .rxd_out(rxd));

  initial forever #25 clk_in = ~clk_in;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
    @(posedge clk_in);
    check({8'h00, v}, {8'h00, e});
  endtask
  task automatic sleep_pulse;
    standby_in <= 1'b1;
    @(posedge clk_in);
    standby_in <= 1'b0;
  endtask
  // Start, data LSB first, parity or mp bit, stop ones
  function automatic logic [11:0] frame(input logic [7:0] d,
      input logic [7:0] f, output int n);
    logic [11:0] v;
    int k;
    v = 12'hFFE;
    k = f[6] ? 7 : 8;
    for (int i = 0; i < k; i++) v[i + 1] = d[i];
    n = k + 1;
    if (f[2]) v[n] = 1'b0;
    else if (f[5]) v[n] = f[4] ^ (^(d & (f[6] ? 8'h7F : 8'hFF)));
    if (f[2] || f[5]) n++;
    n = n + (f[3] ? 2 : 1);
    return v;
  endfunction

  task automatic t_reset;
    rc(o_fmt, 8'h00);
    rc(o_tx, 8'hFF);
    rc(o_flg, 8'h84);
    rc(3'h6, 8'h00);
    rc(o_rx, 8'h00);
    wr(o_rx, 8'h5A);
    rc(o_rx, 8'h00);
    wr(o_tx, 8'h3C);
    rc(o_tx, 8'h3C);
    wr(o_fmt, 8'h6B);
    rc(o_fmt, 8'h6B);
    sleep_pulse;
    rc(o_tx, 8'hFF);
    sleep_pulse;
    rc(o_fmt, 8'h00);
    wr(`SDPF_OFS_RATE, 8'h00);
    $display("reset and access test done");
  endtask
  task automatic t_gate;
    logic [15:0] low;
    low = 16'h0000;
    wr(o_flg, 8'h7E);
    rc(o_flg, 8'h84);
    wr(o_ctl, 8'h20);
    // Flag still set, so nothing may leave the buffer
    repeat (300) begin
      @(negedge clk_in);
      if (txd_out !== 1'b1) low++;
    end
    check(low, 16'h0000);
    $display("transmit gate test done");
  endtask
  task automatic t_tx(input logic [7:0] f, input logic [7:0] d);
    logic [11:0] got;
    logic [11:0] exp;
    int n;
    int bt;
    exp = frame(d, f, n);
    bt = 16 << {f[1:0], 1'b0};
    wr(o_fmt, f);
    wr(o_tx, d);
    fork
      far.grab(n, bt, got);
      wr(o_flg, 8'h7E);
    join
    repeat (bt) @(posedge clk_in);
    check({4'h0, got}, {4'h0, exp});
    $display("transmit format test done");
  endtask
  task automatic t_b2b;
    logic [11:0] g1;
    logic [11:0] g2;
    int n;
    wr(o_fmt, 8'h00);
    wr(o_tx, 8'h81);
    fork
      far.grab(10, 16, g1);
      begin
        wr(o_flg, 8'h7E);
        repeat (30) @(posedge clk_in);
        wr(o_tx, 8'h7E);
        wr(o_flg, 8'h7E);
      end
    join
    far.grab(10, 16, g2);
    check({4'h0, g1}, {4'h0, frame(8'h81, 8'h00, n)});
    check({4'h0, g2}, {4'h0, frame(8'h7E, 8'h00, n)});
    $display("back to back test done");
  endtask
  task automatic t_sync;
    logic [11:0] got;
    // Sync must ignore length, parity, stop and mp fields
    wr(o_fmt, 8'hFC);
    wr(o_tx, 8'h86);
    fork
      far.grab(9, 4, got);
      wr(o_flg, 8'h7E);
    join
    repeat (8) @(posedge clk_in);
    check({4'h0, got}, 16'h0F86);
    $display("synchronous transmit test done");
  endtask
  task automatic t_rx;
    logic [11:0] fa;
    logic [11:0] fb;
    int n;
    wr(o_ctl, 8'h10);
    wr(o_fmt, 8'h00);
    fa = frame(8'h3C, 8'h00, n);
    far.send({12'hFFF, fa}, n, 16);
    repeat (40) @(posedge clk_in);
    rc(o_rx, 8'h3C);
    wr(o_flg, 8'h00);
    wr(o_fmt, 8'h60);
    fa = frame(8'hD5, 8'h60, n);
    far.send({12'hFFF, fa}, n, 16);
    repeat (40) @(posedge clk_in);
    rc(o_rx, 8'h55);
    wr(o_flg, 8'h00);
    fa = frame(8'h2A, 8'h60, n);
    fa[8] = ~fa[8];
    far.send({12'hFFF, fa}, n, 16);
    repeat (40) @(posedge clk_in);
    rc(o_rx, 8'h55);
    rc(o_flg, 8'h8C);
    wr(o_flg, 8'h00);
    // Two stop bits set, yet the next start sits in the second slot
    wr(o_fmt, 8'h08);
    fa = frame(8'hC3, 8'h00, n);
    fb = frame(8'h69, 8'h00, n);
    fork
      far.send({4'hF, fb[9:0], fa[9:0]}, 22, 16);
      begin
        repeat (180) @(posedge clk_in);
        rc(o_rx, 8'hC3);
        wr(o_flg, 8'h00);
      end
    join
    repeat (40) @(posedge clk_in);
    rc(o_rx, 8'h69);
    rc(o_flg, 8'hC4);
    $display("receive test done");
  endtask

  task automatic print_verdict;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_gate;
    foreach (fm[i]) t_tx(fm[i], dt[i]);
    t_sync;
    t_b2b;
    t_rx;
    print_verdict;
  end
endmodule
